// >>> hw/rtc_timer_alarm.sv
/*
 * 32-bit oscillator-driven timer with three equality alarms, set and
 * snapshot transfers through a holding register, auto clear on alarm 0
 * and a missing-clock detector.
 * assumes the oscillator arrives as a slow pin (rtc_osc) sampled on mclk,
 * and a plain register port with read data one cycle after the strobe.
 */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps

// Behaviour
// R1 - run bit: count every oscillator cycle, else hold
// R2 - alarms routable to interrupt, wake, reset
// R3 - auto clear zeroes timer after alarm 0 drops
// R4 - software programs alarm 0 two/four below
// R5 - transfers work while timer is running
// R6 - load request copies holding into timer
// R7 - snapshot request copies timer into holding
// R8 - fast mode transfers on system clock
// R9 - slow mode needs running, within two cycles
// R10 - alarm on exact equality only
// R11 - software disables alarms before changing match
// R12 - clearing alarm enable clears its flag
// R13 - unchanged match refires only after wrap
// R14 - only alarm 0 triggers auto clear
// R15 - timer wraps to zero and keeps counting
// R16 - control bit 7 enables oscillator
// R17 - control bit 6 enables missing-clock detector
// R18 - timeout sets fail flag, software clears
// R19 - run, fast, load, snapshot bit positions
// R20 - reserved bit 3 reads zero
// R21 - timeout after level held over 100 us
// R22 - auto clear has own configuration bit
// R23 - flags set by hardware, cleared writing 0
// R24 - requests cross safely, none lost or doubled
module rtc_timer_alarm #(
   parameter int TW      = 32,
   parameter int NALARM  = 3,
   parameter int MCD_LIM = rtc_pkg::MCD_CYCLES
) (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       rtc_osc,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   output logic            osc_enable_bit,
   output logic            missing_clk_detector_enable,
   output logic            alarm_irq,
   output logic            alarm_wake,
   output logic            alarm_reset
);

   function automatic logic [7:0] get_byte(input logic [TW-1:0] w, input logic [1:0] i);
      get_byte = w[{i, 3'b000} +: 8];
   endfunction

   function automatic logic [TW-1:0] put_byte(input logic [TW-1:0] w, input logic [1:0] i,
                                              input logic [7:0] b);
      logic [TW-1:0] r;
      r = w;
      r[{i, 3'b000} +: 8] = b;
      put_byte = r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reset release and oscillator sampling

   logic             rst_meta_n;
   logic             rst_sync_n;
   logic             osc_meta;
   logic             osc_sync;
   logic             osc_prev;
   logic             tick;
   logic             osc_edge;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // single clock domain: the oscillator is a sampled level, so every
   // request is served on mclk and cannot be lost or doubled
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         osc_meta <= rtc_osc; // R24
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   assign tick     = osc_sync & ~osc_prev & osc_enable_bit;
   assign osc_edge = osc_sync ^ osc_prev;

   ////////////////////////////////////////////////////////////////////////
   // register decode

   logic [7:0]       al_off;
   logic             hold_sel;
   logic             al_sel;
   logic [1:0]       al_idx;
   logic             ctrl_wr;
   logic             cfg_wr;
   logic             route_wr;

   assign al_off   = addr - rtc_pkg::ALARM_BASE;
   assign al_idx   = al_off[3:2];
   assign hold_sel = addr[7:2] == rtc_pkg::HOLD_BASE[7:2];
   assign al_sel   = (addr >= rtc_pkg::ALARM_BASE) && (al_off < rtc_pkg::ALARM_SPAN);
   assign ctrl_wr  = wr && addr == rtc_pkg::CTRL_ADDR;
   assign cfg_wr   = wr && addr == rtc_pkg::CFG_ADDR;
   assign route_wr = wr && addr == rtc_pkg::ROUTE_ADDR;

   ////////////////////////////////////////////////////////////////////////
   // control register

   logic             timer_run_control;
   logic             fast_transfer_mode;
   logic             timer_load_request;
   logic             timer_snapshot_request;
   logic             osc_fail_flag;
   logic             load_do;
   logic             snap_do;
   logic             mcd_fire;
   logic             next_load;
   logic             next_snap;
   logic             next_fail;

   // fast mode serves at once; slow mode waits for a running oscillator edge
   assign load_do   = timer_load_request
                      & (fast_transfer_mode | (tick & timer_run_control)); // R8 R9
   assign snap_do   = timer_snapshot_request
                      & (fast_transfer_mode | (tick & timer_run_control)); // R8 R9
   // set wins over the completion clear
   assign next_load = (ctrl_wr & wdata[rtc_pkg::CTRL_LOAD]) | (timer_load_request & ~load_do);
   assign next_snap = (ctrl_wr & wdata[rtc_pkg::CTRL_SNAP])
                      | (timer_snapshot_request & ~snap_do);
   // writing 1 cannot set the fail flag; a timeout in the clearing cycle wins
   assign next_fail = mcd_fire
                      | (osc_fail_flag & ~(ctrl_wr & ~wdata[rtc_pkg::CTRL_OSC_FAIL])); // R18

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         osc_enable_bit              <= 1'b0;
         missing_clk_detector_enable <= 1'b0;
         timer_run_control           <= 1'b0;
         fast_transfer_mode          <= 1'b0;
      end else if (ctrl_wr) begin
         osc_enable_bit              <= wdata[rtc_pkg::CTRL_OSC_EN]; // R16
         missing_clk_detector_enable <= wdata[rtc_pkg::CTRL_MCD_EN]; // R17
         timer_run_control           <= wdata[rtc_pkg::CTRL_RUN];    // R19
         fast_transfer_mode          <= wdata[rtc_pkg::CTRL_FAST];   // R19
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         timer_load_request     <= 1'b0;
         timer_snapshot_request <= 1'b0;
         osc_fail_flag          <= 1'b0;
      end else begin
         timer_load_request     <= next_load; // R6
         timer_snapshot_request <= next_snap; // R7
         osc_fail_flag          <= next_fail;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // missing-clock detector: counts mclk cycles without an oscillator edge

   // counter sized from the limit so a longer timeout cannot wrap it
   localparam int MCD_W = $clog2(MCD_LIM + 1);

   logic [MCD_W-1:0] mcd_cnt;
   logic             mcd_active;

   assign mcd_active = missing_clk_detector_enable & osc_enable_bit;
   // fires once per stall; the count saturates until the next edge
   assign mcd_fire   = mcd_active & ~osc_edge && mcd_cnt == MCD_W'(MCD_LIM - 1); // R21

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mcd_cnt <= '0;
      end else if (!mcd_active || osc_edge) begin
         mcd_cnt <= '0;
      end else if (mcd_cnt != MCD_W'(MCD_LIM)) begin
         mcd_cnt <= mcd_cnt + MCD_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timer, holding register, alarm match

   logic [TW-1:0]    timer;
   logic [TW-1:0]    transfer_holding_regs;
   logic [TW-1:0]    alarm_match_regs [NALARM];
   logic [NALARM-1:0] alarm_event_enable;
   logic [NALARM-1:0] alarm_event_flag;
   logic [NALARM-1:0] eq;
   logic [NALARM-1:0] eq_prev;
   logic [NALARM-1:0] ev;
   logic [NALARM-1:0] flag_clr;
   logic             auto_clear_enable;
   logic             clr_pend;
   logic             step;
   logic [2:0]       route;

   assign step = tick & timer_run_control; // R1

   always_comb begin
      for (int i = 0; i < NALARM; i++) begin
         eq[i]       = timer == alarm_match_regs[i]; // R10
         // only the entry into equality counts, so re-enabling on a held
         // match waits for the wrap
         ev[i]       = alarm_event_enable[i] & eq[i] & ~eq_prev[i]; // R13
         flag_clr[i] = cfg_wr & (~wdata[rtc_pkg::CFG_FLAG_LSB + i]
                                 | ~wdata[rtc_pkg::CFG_EN_LSB + i]); // R12 R23
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         timer <= rtc_pkg::WORD_RESET;
      end else if (load_do) begin
         timer <= transfer_holding_regs; // R6 R5
      end else if (step && clr_pend) begin
         timer <= rtc_pkg::WORD_RESET; // R3
      end else if (step) begin
         timer <= timer + rtc_pkg::TIMER_STEP; // R1 R15
      end
   end

   // armed while alarm 0 matches, applied on the following oscillator cycle
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         clr_pend <= 1'b0;
      end else if (load_do) begin
         clr_pend <= 1'b0;
      end else if (step) begin
         clr_pend <= auto_clear_enable & alarm_event_enable[0] & eq[0]; // R14 R22
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         transfer_holding_regs <= rtc_pkg::WORD_RESET;
      end else if (snap_do) begin
         transfer_holding_regs <= timer; // R7 R5
      end else if (wr && hold_sel) begin
         transfer_holding_regs <= put_byte(transfer_holding_regs, addr[1:0], wdata);
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int i = 0; i < NALARM; i++) alarm_match_regs[i] <= rtc_pkg::WORD_RESET;
      end else if (wr && al_sel) begin
         alarm_match_regs[al_idx] <= put_byte(alarm_match_regs[al_idx], al_off[1:0], wdata);
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         alarm_event_enable <= '0;
         auto_clear_enable  <= 1'b0;
         route              <= '0;
      end else begin
         if (cfg_wr) begin
            alarm_event_enable <= wdata[rtc_pkg::CFG_EN_LSB +: NALARM];
            auto_clear_enable  <= wdata[rtc_pkg::CFG_AUTO_CLR]; // R22
         end
         if (route_wr) begin
            route <= wdata[2:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         eq_prev          <= '0;
         alarm_event_flag <= '0;
      end else begin
         eq_prev          <= eq;
         // an event in the disabling cycle shows for one cycle, then drops
         alarm_event_flag <= ev | (alarm_event_flag & ~flag_clr & alarm_event_enable); // R12 R23
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alarm routing and read port

   logic [7:0]       ctrl_rd;
   logic [7:0]       cfg_rd;
   logic [7:0]       rd_mux;

   assign ctrl_rd = {osc_enable_bit, missing_clk_detector_enable, osc_fail_flag,
                     timer_run_control, 1'b0, fast_transfer_mode, timer_load_request,
                     timer_snapshot_request}; // R20
   assign cfg_rd  = {1'b0, alarm_event_flag, auto_clear_enable, alarm_event_enable};

   assign rd_mux = hold_sel                          ? get_byte(transfer_holding_regs, addr[1:0])
                 : al_sel                            ? get_byte(alarm_match_regs[al_idx],
                                                                al_off[1:0])
                 : (addr == rtc_pkg::CTRL_ADDR)      ? ctrl_rd
                 : (addr == rtc_pkg::CFG_ADDR)       ? cfg_rd
                 : (addr == rtc_pkg::ROUTE_ADDR)     ? {5'h00, route}
                 : rtc_pkg::REG_RESET;

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata       <= rtc_pkg::REG_RESET;
         alarm_irq   <= 1'b0;
         alarm_wake  <= 1'b0;
         alarm_reset <= 1'b0;
      end else begin
         rdata       <= rd ? rd_mux : rtc_pkg::REG_RESET;
         alarm_irq   <= (|alarm_event_flag) & route[rtc_pkg::ROUTE_IRQ];   // R2
         alarm_wake  <= (|alarm_event_flag) & route[rtc_pkg::ROUTE_WAKE];  // R2
         alarm_reset <= (|alarm_event_flag) & route[rtc_pkg::ROUTE_RESET]; // R2
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_sync_n);

   property p_count;
      step && !load_do && !clr_pend |=> timer == $past(timer) + rtc_pkg::TIMER_STEP;
   endproperty
   a_count: assert property (p_count) else $error("timer did not advance"); // R1

   property p_hold;
      !step && !load_do |=> $stable(timer);
   endproperty
   a_hold: assert property (p_hold) else $error("timer moved without a tick"); // R1

   property p_autoclr;
      step && clr_pend && !load_do |=> timer == rtc_pkg::WORD_RESET;
   endproperty
   a_autoclr: assert property (p_autoclr) else $error("auto clear missed"); // R3

   property p_load;
      load_do |=> timer == $past(transfer_holding_regs) && !timer_load_request;
   endproperty
   a_load: assert property (p_load) else $error("load transfer wrong"); // R6

   property p_snap;
      snap_do |=> transfer_holding_regs == $past(timer);
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot wrong"); // R7

   property p_fast;
      fast_transfer_mode && timer_load_request && !ctrl_wr |=> !timer_load_request;
   endproperty
   a_fast: assert property (p_fast) else $error("fast load not done in one cycle"); // R8

   property p_alarm;
      alarm_event_enable[0] && eq[0] && !eq_prev[0] |=> alarm_event_flag[0];
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm 0 flag not set"); // R10

   property p_en_clr;
      !alarm_event_enable[1] && $past(!alarm_event_enable[1]) |-> !alarm_event_flag[1];
   endproperty
   a_en_clr: assert property (p_en_clr) else $error("flag set while disabled"); // R12

   property p_mcd;
      mcd_fire |=> osc_fail_flag;
   endproperty
   a_mcd: assert property (p_mcd) else $error("timeout did not set fail flag"); // R18

   property p_rsvd;
      rd && addr == rtc_pkg::CTRL_ADDR |=> !rdata[rtc_pkg::CTRL_RSVD];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one"); // R20

   c_autoclr: cover property (step && clr_pend);
   c_slow_load: cover property (!fast_transfer_mode && load_do);
   c_timeout: cover property (mcd_fire);

endmodule

// >>> shared/rtc_pkg.sv
/*
 * constants for the timer and alarm unit: register offsets, field positions,
 * reset values and timing figures.
 * assumes an 8-bit register port and a 40 MHz system clock.
 */
package rtc_pkg;

   // register offsets
   localparam logic [7:0] HOLD_BASE  = 8'h00;
   localparam logic [7:0] CTRL_ADDR  = 8'h04;
   localparam logic [7:0] CFG_ADDR   = 8'h07;
   localparam logic [7:0] ALARM_BASE = 8'h08;
   localparam logic [7:0] ALARM_SPAN = 8'h0c;
   localparam logic [7:0] ROUTE_ADDR = 8'h14;

   // control register fields
   localparam int CTRL_OSC_EN   = 7;
   localparam int CTRL_MCD_EN   = 6;
   localparam int CTRL_OSC_FAIL = 5;
   localparam int CTRL_RUN      = 4;
   localparam int CTRL_RSVD     = 3;
   localparam int CTRL_FAST     = 2;
   localparam int CTRL_LOAD     = 1;
   localparam int CTRL_SNAP     = 0;

   // configuration register fields
   localparam int CFG_FLAG_LSB  = 4;
   localparam int CFG_AUTO_CLR  = 3;
   localparam int CFG_EN_LSB    = 0;

   // alarm routing register fields
   localparam int ROUTE_IRQ     = 0;
   localparam int ROUTE_WAKE    = 1;
   localparam int ROUTE_RESET   = 2;

   localparam logic [7:0]  REG_RESET  = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [31:0] TIMER_STEP = 32'h0000_0001;

   // missing-clock timeout
   localparam int CLK_MHZ     = 40;
   localparam int MCD_TIME_US = 100;
   localparam int MCD_CYCLES  = MCD_TIME_US * CLK_MHZ;

endpackage

// >>> verification/rtc_timer_alarm_unit_test.sv
/*
 * self-checking bench for the timer and alarm unit: register port, set and
 * snapshot transfers, alarms, auto clear and the missing-clock detector.
 * assumes rtc_pkg, a 40 MHz mclk and a detector limit cut to 20 cycles.
 */
`timescale 1ns/100ps
module rtc_timer_alarm_unit_test;
   localparam int         LIM = 20;
   localparam logic [7:0] CTL = rtc_pkg::CTRL_ADDR;
   localparam logic [7:0] CFG = rtc_pkg::CFG_ADDR;
   localparam logic [7:0] HB  = rtc_pkg::HOLD_BASE;
   localparam logic [7:0] AL  = rtc_pkg::ALARM_BASE;
   localparam logic [7:0] RT  = rtc_pkg::ROUTE_ADDR;
   localparam logic [7:0] F   = 8'h84;
   localparam logic [7:0] FR  = 8'h94;

   logic       mclk    = 1'b0;
   logic       rst_n   = 1'b0;
   logic       rtc_osc = 1'b0;
   logic [7:0] addr    = 8'h00;
   logic [7:0] wdata   = 8'h00;
   logic       wr      = 1'b0;
   logic       rd      = 1'b0;
   logic [7:0] rdata;
   logic       osc_enable_bit;
   logic       missing_clk_detector_enable;
   logic       alarm_irq;
   logic       alarm_wake;
   logic       alarm_reset;
   int         n_mismatch = 0;
   int         n_compared = 0;

   rtc_timer_alarm #(.MCD_LIM(LIM)) i_rtc_timer_alarm (
      .mclk                        (mclk),
      .rst_n                       (rst_n),
      .rtc_osc                     (rtc_osc),
      .addr                        (addr),
      .wdata                       (wdata),
      .wr                          (wr),
      .rd                          (rd),
      .rdata                       (rdata),
      .osc_enable_bit              (osc_enable_bit),
      .missing_clk_detector_enable (missing_clk_detector_enable),
      .alarm_irq                   (alarm_irq),
      .alarm_wake                  (alarm_wake),
      .alarm_reset                 (alarm_reset)
   );

   initial begin
      forever begin
         #12.5 mclk = ~mclk;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string s);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string s);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe edge
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic wr_word(input logic [7:0] a, input logic [31:0] v);
      for (int i = 0; i < 4; i++) begin
         wr_reg(a + 8'(i), v[8*i +: 8]);
      end
   endtask

   task automatic rd_word(input logic [7:0] a, output logic [31:0] v);
      logic [7:0] b;
      for (int i = 0; i < 4; i++) begin
         rd_reg(a + 8'(i), b);
         v[8*i +: 8] = b;
      end
   endtask

   task automatic wait_clear(input int b);
      logic [7:0] c;
      for (int k = 0; k < 50; k++) begin
         rd_reg(CTL, c);
         if (c[b] === 1'b0) return;
      end
      n_mismatch++;
      $display("MISMATCH %0t request bit stuck", $time);
      end_of_test();
   endtask

   // oscillator stands still between pulses, far below the detector limit
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge mclk);
         rtc_osc <= 1'b1;
         repeat (4) @(posedge mclk);
         rtc_osc <= 1'b0;
         repeat (4) @(posedge mclk);
      end
   endtask

   task automatic set_timer(input logic [31:0] v, input logic [7:0] base);
      wr_word(HB, v);
      wr_reg(CTL, base | 8'h02);
      wait_clear(rtc_pkg::CTRL_LOAD);
   endtask

   task automatic get_timer(input logic [7:0] base, output logic [31:0] v);
      wr_reg(CTL, base | 8'h01);
      wait_clear(rtc_pkg::CTRL_SNAP);
      rd_word(HB, v);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] d;
      rd_reg(CTL, d);
      chk_byte(d, 8'h00, "control reset");
      rd_reg(CFG, d);
      chk_byte(d, 8'h00, "config reset");
      wr_reg(8'h30, 8'hff);
      rd_reg(8'h30, d);
      chk_byte(d, 8'h00, "unmapped read");
      wr_reg(CTL, 8'h88);
      rd_reg(CTL, d);
      chk_byte(d, 8'h80, "reserved bit");
      chk_byte({6'h0, osc_enable_bit, missing_clk_detector_enable}, 8'h02, "osc pin");
      wr_reg(CTL, 8'h40);
      @(posedge mclk);
      #1;
      chk_byte({6'h0, osc_enable_bit, missing_clk_detector_enable}, 8'h01, "mcd pin");
      wr_reg(CTL, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_fast();
      logic [31:0] v;
      set_timer(32'h1234_5678, F);
      pulse(2);
      get_timer(F, v);
      chk_word(v, 32'h1234_5678, "stopped timer holds");
      set_timer(32'hffff_fffe, FR);
      pulse(3);
      get_timer(FR, v);
      chk_word(v, 32'h0000_0001, "wrap and count");
      $display("test fast done");
   endtask

   task automatic t_slow();
      logic [7:0]  d;
      logic [31:0] v;
      wr_word(HB, 32'h0000_0100);
      wr_reg(CTL, 8'h82);
      pulse(2);
      rd_reg(CTL, d);
      chk_byte(d, 8'h82, "load waits while stopped");
      wr_reg(CTL, 8'h92);
      pulse(2);
      rd_reg(CTL, d);
      chk_byte(d, 8'h90, "slow load in two ticks");
      wr_reg(CTL, 8'h91);
      pulse(2);
      rd_reg(CTL, d);
      chk_byte(d, 8'h90, "slow snapshot in two ticks");
      rd_word(HB, v);
      chk_word(v & 32'hffff_fffc, 32'h0000_0100, "slow snapshot value");
      get_timer(F, v);
      chk_word(v, 32'h0000_0103, "load then count");
      $display("test slow done");
   endtask

   task automatic t_alarm();
      logic [7:0] d;
      wr_reg(RT, 8'h01);
      wr_reg(CFG, 8'h00);
      wr_word(AL, 32'h0000_0010);
      set_timer(32'h0000_000e, FR);
      wr_reg(CFG, 8'h01);
      pulse(1);
      rd_reg(CFG, d);
      chk_byte(d, 8'h01, "no alarm below match");
      pulse(1);
      rd_reg(CFG, d);
      chk_byte(d, 8'h11, "alarm on equality");
      for (int r = 0; r < 3; r++) begin
         wr_reg(RT, 8'h01 << r);
         @(posedge mclk);
         #1;
         chk_byte({5'h0, alarm_reset, alarm_wake, alarm_irq}, 8'h01 << r, "routing");
      end
      wr_reg(CFG, 8'h11);
      rd_reg(CFG, d);
      chk_byte(d, 8'h11, "writing one to flag");
      wr_reg(CFG, 8'h00);
      rd_reg(CFG, d);
      chk_byte(d, 8'h00, "disable clears flag");
      wr_reg(CFG, 8'h01);
      rd_reg(CFG, d);
      chk_byte(d, 8'h01, "held match does not refire");
      $display("test alarm done");
   endtask

   task automatic t_auto();
      logic [7:0]  d;
      logic [31:0] v;
      logic [31:0] m;
      for (int i = 0; i < 3; i++) begin
         m = 32'h20 << i;
         wr_reg(CFG, 8'h00);
         wr_word(AL + 8'(4 * i), m);
         set_timer(m - 32'h1, FR);
         wr_reg(CFG, 8'h08 | (8'h01 << i));
         pulse(4);
         get_timer(FR, v);
         chk_word(v, (i == 0) ? 32'h1 : m + 32'h3, "auto clear");
         rd_reg(CFG, d);
         chk_byte(d, 8'h08 | (8'h11 << i), "alarm flag");
         wr_reg(CFG, 8'h08 | (8'h01 << i));
         rd_reg(CFG, d);
         chk_byte(d, 8'h08 | (8'h01 << i), "flag cleared by zero");
      end
      $display("test auto clear done");
   endtask

   task automatic t_mcd();
      logic [7:0] d;
      wr_reg(CTL, 8'hc0);
      rd_reg(CTL, d);
      chk_byte(d, 8'hc0, "no early timeout");
      repeat (2 * LIM) @(posedge mclk);
      rd_reg(CTL, d);
      chk_byte(d, 8'he0, "timeout sets fail");
      wr_reg(CTL, 8'h80);
      rd_reg(CTL, d);
      chk_byte(d, 8'h80, "fail cleared");
      $display("test detector done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_regs();
      t_fast();
      t_slow();
      t_alarm();
      t_auto();
      t_mcd();
      end_of_test();
   end
endmodule
